// *** verilog/lcdc_map.svh ***
// Constants of the character display command decoder: opcodes, field bits,
// reset values and memory sizes. Definitions only; included by the decoder.
`ifndef LCDC_MAP_SVH
`define LCDC_MAP_SVH

// Instruction classes as mask / match pairs on the command byte
`define LCDC_CLR_MASK   8'hff
`define LCDC_CLR_VAL    8'h01
`define LCDC_HOME_MASK  8'hfe
`define LCDC_HOME_VAL   8'h02
`define LCDC_ENTRY_MASK 8'hfc
`define LCDC_ENTRY_VAL  8'h04
`define LCDC_DISP_MASK  8'hf8
`define LCDC_DISP_VAL   8'h08
`define LCDC_SHIFT_MASK 8'hf0
`define LCDC_SHIFT_VAL  8'h10
`define LCDC_FSET_MASK  8'he0
`define LCDC_FSET_VAL   8'h20
`define LCDC_ADDR_MASK  8'h80
`define LCDC_ADDR_VAL   8'h80

// Field bit positions
`define LCDC_B_ENTRY_INC  1
`define LCDC_B_ENTRY_SHF  0
`define LCDC_B_DISP_ON    2
`define LCDC_B_CURS_ON    1
`define LCDC_B_BLINK_ON   0
`define LCDC_B_FONT_WIDE  2
`define LCDC_B_FOUR_LINE  0
`define LCDC_B_SC_DISPLAY 3
`define LCDC_B_SC_RIGHT   2
`define LCDC_B_IF_8BIT    4
`define LCDC_B_TWO_LINE   3
`define LCDC_B_EXT_PAGE   2
`define LCDC_B_DBL_HEIGHT 1

// Reset values, fill code and memory sizes
`define LCDC_RST_SHIFT_EN 4'hf
`define LCDC_BLANK_CODE   8'h20
`define LCDC_ADDR_W       7
`define LCDC_DATA_W       8

`endif

// *** verilog/lcdc_pkg.sv ***
// Types shared by the command decoder, the host model and the bench.
// Assumes lcdc_map.svh for the numeric constants.
package lcdc_pkg;
    // One host transfer on the parallel port
    typedef struct packed {
        logic       register_select;
        logic       read_write;
        logic [7:0] data;
    } lcdc_xfer_t;

    // Display on/off control fields
    typedef struct packed {
        logic display_on;
        logic cursor_on;
        logic blink_on;
    } lcdc_disp_t;

    typedef enum logic [0:0] {
        LCDC_IDLE  = 1'b0,
        LCDC_CLEAR = 1'b1
    } lcdc_state_t;
endpackage

// *** verilog/lcdc_text_mem.sv ***
// Display text memory: one write port, one read port with registered data.
// Assumes a single clock; contents are not reset, the decoder blanks them.
`timescale 1ns/1ps
module lcdc_text_mem #(
    parameter int ADDR_W = 7,
    parameter int DATA_W = 8
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Elaboration check: a zero-width port cannot hold a character
    if (ADDR_W < 1 || DATA_W < 1) begin : g_bad_size
        $error("lcdc_text_mem: bad size");
    end

    // Array write; no reset so it maps onto a RAM
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read register, cleared so the port is defined from reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// *** verilog/lcdc_decoder.sv ***
// Command decoder of a character display controller with its text memory.
// Assumes host transfers arrive as one-cycle strobes synchronous to clk.
`timescale 1ns/1ps
`include "lcdc_map.svh"
module lcdc_decoder import lcdc_pkg::*; #(
    parameter int ADDR_W = `LCDC_ADDR_W
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   host_strobe,
    input  wire lcdc_xfer_t             host_xfer,
    input  wire logic [ADDR_W-1:0]      scan_addr,
    output logic      [7:0]             scan_data,
    output logic                        busy,
    output logic      [ADDR_W-1:0]      cursor_addr,
    output logic      [3:0][ADDR_W-1:0] line_shift,
    output lcdc_disp_t                  disp_ctrl,
    output logic                        entry_increment,
    output logic                        entry_shift,
    output logic                        ext_cmd_page,
    output logic                        double_height,
    output logic                        iface_8bit,
    output logic                        two_line,
    output logic                        four_line,
    output logic                        font_wide,
    output logic                        line4_shift_enable,
    output logic      [1:0]             line3_line2_shift_enable,
    output logic                        line1_shift_enable
);
    // Elaboration check: the line start addresses only fit a 7-bit cursor
    if (ADDR_W != `LCDC_ADDR_W) begin : g_bad_addr_w
        $error("lcdc_decoder: line start addresses need a 7-bit address");
    end

    function automatic logic op_is(input logic [7:0] b, input logic [7:0] m,
                                   input logic [7:0] v);
        return (b & m) == v;
    endfunction

    // Moves every enabled line one place left (up) or right (down)
    function automatic logic [3:0][ADDR_W-1:0] shift_lines(
            input logic [3:0][ADDR_W-1:0] cur, input logic [3:0] en,
            input logic left);
        logic [3:0][ADDR_W-1:0] r;
        r = cur;
        for (int i = 0; i < 4; i++) begin
            if (en[i]) begin
                r[i] = left ? cur[i] + 1'b1 : cur[i] - 1'b1;
            end
        end
        return r;
    endfunction

    lcdc_state_t       state;
    logic [ADDR_W-1:0] clr_cnt;
    logic [3:0]        shift_en;
    logic              take;
    logic              cmd;
    logic              wr;
    logic [7:0]        b;
    logic              is_clr;
    logic              is_home;
    logic              is_entry;
    logic              is_disp;
    logic              is_shift;
    logic              is_fset;
    logic              is_addr;
    logic              mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [7:0]        mem_wdata;

    // Transfers during a clear are dropped; the host must watch busy
    assign take     = host_strobe && !busy;
    assign cmd      = take && !host_xfer.register_select && !host_xfer.read_write;
    assign wr       = take && host_xfer.register_select && !host_xfer.read_write;
    assign b        = host_xfer.data;
    assign is_clr   = cmd && op_is(b, `LCDC_CLR_MASK, `LCDC_CLR_VAL);
    assign is_home  = cmd && !ext_cmd_page && op_is(b, `LCDC_HOME_MASK, `LCDC_HOME_VAL);
    assign is_entry = cmd && !ext_cmd_page && op_is(b, `LCDC_ENTRY_MASK, `LCDC_ENTRY_VAL);
    assign is_disp  = cmd && op_is(b, `LCDC_DISP_MASK, `LCDC_DISP_VAL);
    assign is_shift = cmd && op_is(b, `LCDC_SHIFT_MASK, `LCDC_SHIFT_VAL);
    assign is_fset  = cmd && op_is(b, `LCDC_FSET_MASK, `LCDC_FSET_VAL);
    assign is_addr  = cmd && !ext_cmd_page && op_is(b, `LCDC_ADDR_MASK, `LCDC_ADDR_VAL);
    assign shift_en = {line4_shift_enable, line3_line2_shift_enable, line1_shift_enable};

    // Clearing owns the write port; otherwise host data goes to the cursor
    assign mem_we    = (state == LCDC_CLEAR) || wr;
    assign mem_waddr = (state == LCDC_CLEAR) ? clr_cnt : cursor_addr;
    assign mem_wdata = (state == LCDC_CLEAR) ? `LCDC_BLANK_CODE : host_xfer.data;

    lcdc_text_mem #(
        .ADDR_W (ADDR_W),
        .DATA_W (`LCDC_DATA_W)
    ) u_mem (
        .clk     (clk),
        .reset   (reset),
        .wr_en   (mem_we),
        .wr_addr (mem_waddr),
        .wr_data (mem_wdata),
        .rd_addr (scan_addr),
        .rd_data (scan_data)
    );

    // Clear sequencer; reset starts a blanking pass so no command is needed
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state   <= LCDC_CLEAR;
            busy    <= 1'b1;
            clr_cnt <= '0;
        end else begin
            case (state)
                LCDC_IDLE: begin
                    if (is_clr) begin
                        state   <= LCDC_CLEAR;
                        busy    <= 1'b1;
                        clr_cnt <= '0;
                    end
                end
                LCDC_CLEAR: begin
                    clr_cnt <= clr_cnt + 1'b1;
                    if (&clr_cnt) begin
                        state <= LCDC_IDLE;
                        busy  <= 1'b0;
                    end
                end
                default: begin
                    state <= LCDC_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // Cursor address counter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cursor_addr <= '0;
        end else if (state == LCDC_CLEAR || is_clr || is_home) begin
            cursor_addr <= '0;
        end else if (wr) begin
            cursor_addr <= entry_increment ? cursor_addr + 1'b1 : cursor_addr - 1'b1;
        end else if (is_shift && !ext_cmd_page && !b[`LCDC_B_SC_DISPLAY]) begin
            cursor_addr <= b[`LCDC_B_SC_RIGHT] ? cursor_addr + 1'b1
                                               : cursor_addr - 1'b1;
        end else if (is_addr) begin
            cursor_addr <= b[ADDR_W-1:0];
        end
    end

    // Per-line display offsets; only enabled lines move
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            line_shift <= '0;
        end else if (is_clr || is_home) begin
            line_shift <= '0;
        end else if (wr && entry_shift) begin
            line_shift <= shift_lines(line_shift, shift_en, entry_increment);
        end else if (is_shift && !ext_cmd_page && b[`LCDC_B_SC_DISPLAY]) begin
            line_shift <= shift_lines(line_shift, shift_en, !b[`LCDC_B_SC_RIGHT]);
        end
    end

    // Entry mode; a clear also restores increment but keeps the shift setting
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            entry_increment <= 1'b1;
            entry_shift     <= 1'b0;
        end else if (is_clr) begin
            entry_increment <= 1'b1;
        end else if (is_entry) begin
            entry_increment <= b[`LCDC_B_ENTRY_INC];
            entry_shift     <= b[`LCDC_B_ENTRY_SHF];
        end
    end

    // Function set: page select, interface width, line count, double height
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_cmd_page  <= 1'b0;
            double_height <= 1'b0;
            iface_8bit    <= 1'b1;
            two_line      <= 1'b0;
        end else if (is_fset) begin
            ext_cmd_page <= b[`LCDC_B_EXT_PAGE];
            iface_8bit   <= b[`LCDC_B_IF_8BIT];
            two_line     <= b[`LCDC_B_TWO_LINE];
            if (!b[`LCDC_B_EXT_PAGE]) begin
                double_height <= b[`LCDC_B_DBL_HEIGHT];
            end
        end
    end

    // Display control on the basic page, extended function set on the other
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            disp_ctrl <= '0;
            four_line <= 1'b0;
            font_wide <= 1'b0;
        end else if (is_disp && !ext_cmd_page) begin
            disp_ctrl.display_on <= b[`LCDC_B_DISP_ON];
            disp_ctrl.cursor_on  <= b[`LCDC_B_CURS_ON];
            disp_ctrl.blink_on   <= b[`LCDC_B_BLINK_ON];
        end else if (is_disp) begin
            font_wide <= b[`LCDC_B_FONT_WIDE];
            four_line <= b[`LCDC_B_FOUR_LINE];
        end
    end

    // Shift enables live on the extended page only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {line4_shift_enable, line3_line2_shift_enable, line1_shift_enable}
                <= `LCDC_RST_SHIFT_EN;
        end else if (is_shift && ext_cmd_page) begin
            {line4_shift_enable, line3_line2_shift_enable, line1_shift_enable}
                <= b[3:0];
        end
    end

    // Checks
    // Looks at the stored word itself, so a broken write path cannot hide
    property p_data_write;
        @(posedge clk) disable iff (reset)
        wr |=> u_mem.mem[$past(cursor_addr)] == $past(host_xfer.data);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write lost");

    property p_inc_write;
        @(posedge clk) disable iff (reset)
        wr && entry_increment && !entry_shift
        |=> cursor_addr == ADDR_W'($past(cursor_addr) + 1) && $stable(line_shift);
    endproperty
    a_inc_write: assert property (p_inc_write) else $error("write did not advance");

    property p_cur_right;
        @(posedge clk) disable iff (reset)
        cmd && !ext_cmd_page && (b & 8'hfc) == 8'h14
        |=> cursor_addr == ADDR_W'($past(cursor_addr) + 1);
    endproperty
    a_cur_right: assert property (p_cur_right) else $error("cursor right wrong");

    property p_cur_left;
        @(posedge clk) disable iff (reset)
        cmd && !ext_cmd_page && (b & 8'hfc) == 8'h10
        |=> cursor_addr == ADDR_W'($past(cursor_addr) - 1) && $stable(line_shift);
    endproperty
    a_cur_left: assert property (p_cur_left) else $error("cursor left wrong");

    property p_entry_shift;
        @(posedge clk) disable iff (reset)
        wr && entry_increment && entry_shift && line1_shift_enable
        |=> line_shift[0] == ADDR_W'($past(line_shift[0]) + 1);
    endproperty
    a_entry_shift: assert property (p_entry_shift) else $error("no display shift");

    property p_disp_left;
        @(posedge clk) disable iff (reset)
        cmd && !ext_cmd_page && (b & 8'hfc) == 8'h18
        |=> $stable(cursor_addr) && (line_shift[3] == ADDR_W'($past(line_shift[3]) + 1)
            || !line4_shift_enable);
    endproperty
    a_disp_left: assert property (p_disp_left) else $error("display shift wrong");

    property p_page;
        @(posedge clk) disable iff (reset)
        cmd && b == 8'h3c |=> ext_cmd_page && iface_8bit;
    endproperty
    a_page: assert property (p_page) else $error("page not extended");

    property p_basic;
        @(posedge clk) disable iff (reset)
        cmd && (b == 8'h38 || b == 8'h3a) |=> !ext_cmd_page && double_height == $past(b[1]);
    endproperty
    a_basic: assert property (p_basic) else $error("basic page not restored");

    property p_disp_on;
        @(posedge clk) disable iff (reset)
        cmd && !ext_cmd_page && b == 8'h0e |=> disp_ctrl == 3'b110;
    endproperty
    a_disp_on: assert property (p_disp_on) else $error("display control wrong");

    property p_set_addr;
        @(posedge clk) disable iff (reset)
        cmd && !ext_cmd_page && b == 8'ha0 |=> cursor_addr == 7'h20;
    endproperty
    a_set_addr: assert property (p_set_addr) else $error("address set wrong");

    sequence s_clear_start;
        cmd && b == 8'h01 && !busy;
    endsequence
    sequence s_clear_done;
        busy [*8] ##[1:130] !busy && cursor_addr == '0;
    endsequence
    property p_clear;
        @(posedge clk) disable iff (reset)
        s_clear_start |=> s_clear_done;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not finish");

    property p_home;
        @(posedge clk) disable iff (reset)
        is_home |=> cursor_addr == '0 && line_shift == '0;
    endproperty
    a_home: assert property (p_home) else $error("home incomplete");
endmodule

// *** test/lcdc_host_model.sv ***
// Host processor model: issues one-cycle transfer strobes on the parallel port.
// Assumes the bench calls xfer at a falling clock edge; busy is waited out first.
`timescale 1ns/1ps
module lcdc_host_model import lcdc_pkg::*; (
    input  wire logic  clk,
    input  wire logic  busy,
    output logic       host_strobe,
    output lcdc_xfer_t host_xfer
);
    // Idle port at time zero
    initial begin
        host_strobe = 1'b0;
        host_xfer   = '0;
    end

    // One transfer. Outside the strobe the bus shows the inverse of the last
    // value, so a decoder that samples without the strobe picks up garbage.
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d);
        int n;
        n = 0;
        while (busy === 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        host_xfer.register_select = rs;
        host_xfer.read_write      = rw;
        host_xfer.data            = d;
        host_strobe               = 1'b1;
        @(negedge clk);
        host_strobe = 1'b0;
        host_xfer   = ~host_xfer;
        // Gap cycle keeps the strobe from being rewritten in one time step
        @(negedge clk);
    endtask
endmodule

// *** test/char_lcd_command_decoder_tb.sv ***
// Self-checking bench of the display command decoder, driven by a host model.
// Assumes lcdc_pkg is compiled first; inputs change on the falling clock edge.
`timescale 1ns/1ps
module char_lcd_command_decoder_tb;
    import lcdc_pkg::*;
    localparam int MAX_CYCLES = 4000;

    logic             clk;
    logic             reset;
    logic             host_strobe;
    lcdc_xfer_t       host_xfer;
    logic [6:0]       scan_addr;
    logic [7:0]       scan_data;
    logic             busy;
    logic [6:0]       cursor_addr;
    logic [3:0][6:0]  line_shift;
    lcdc_disp_t       disp_ctrl;
    logic             entry_increment;
    logic             entry_shift;
    logic             ext_cmd_page;
    logic             double_height;
    logic             iface_8bit;
    logic             two_line;
    logic             four_line;
    logic             font_wide;
    logic             line4_shift_enable;
    logic [1:0]       line3_line2_shift_enable;
    logic             line1_shift_enable;
    int               n_errors = 0;
    int               comparisons = 0;
    int               cycles = 0;
    logic [7:0]       n;
    logic [7:0]       line_start [3] = '{8'ha0, 8'hc0, 8'he0};

    lcdc_decoder u_lcdc_decoder (
        .clk                      (clk),
        .reset                    (reset),
        .host_strobe              (host_strobe),
        .host_xfer                (host_xfer),
        .scan_addr                (scan_addr),
        .scan_data                (scan_data),
        .busy                     (busy),
        .cursor_addr              (cursor_addr),
        .line_shift               (line_shift),
        .disp_ctrl                (disp_ctrl),
        .entry_increment          (entry_increment),
        .entry_shift              (entry_shift),
        .ext_cmd_page             (ext_cmd_page),
        .double_height            (double_height),
        .iface_8bit               (iface_8bit),
        .two_line                 (two_line),
        .four_line                (four_line),
        .font_wide                (font_wide),
        .line4_shift_enable       (line4_shift_enable),
        .line3_line2_shift_enable (line3_line2_shift_enable),
        .line1_shift_enable       (line1_shift_enable)
    );

    lcdc_host_model u_lcdc_host_model (
        .clk         (clk),
        .busy        (busy),
        .host_strobe (host_strobe),
        .host_xfer   (host_xfer)
    );

    // 200 MHz clock
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    task automatic final_report;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == MAX_CYCLES) begin
            n_errors++;
            final_report();
        end
    end

    task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_flag(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic cmd(input logic [7:0] d);
        u_lcdc_host_model.xfer(1'b0, 1'b0, d);
    endtask

    task automatic put(input logic [7:0] d);
        u_lcdc_host_model.xfer(1'b1, 1'b0, d);
    endtask

    // Scan read: address at one falling edge, data settled by the next
    task automatic peek(input logic [6:0] a, input logic [7:0] exp);
        scan_addr = a;
        @(negedge clk);
        check_val("scan_data", exp, scan_data);
    endtask

    task automatic cur(input logic [7:0] exp);
        check_val("cursor_addr", exp, {1'b0, cursor_addr});
    endtask

    // Counts falling edges until the blanking pass ends, bounded
    task automatic wait_idle(output logic [7:0] cnt);
        cnt = 8'h00;
        while (busy !== 1'b0 && cnt < 8'hc8) begin
            @(negedge clk);
            cnt++;
        end
    endtask

    // Main sequence
    initial begin
        reset     = 1'b1;
        scan_addr = 7'h00;
        repeat (12) @(negedge clk);
        check_flag("busy", 1'b1, busy);
        check_flag("entry_increment", 1'b1, entry_increment);
        reset = 1'b0;
        wait_idle(n);
        check_val("blank_cycles", 8'h80, n);
        peek(7'h05, 8'h20);
        cmd(8'h38);
        check_flag("ext_cmd_page", 1'b0, ext_cmd_page);
        check_flag("iface_8bit", 1'b1, iface_8bit);
        check_flag("two_line", 1'b1, two_line);
        cmd(8'h0e);
        check_val("disp_ctrl", 8'h06, {5'h00, disp_ctrl});
        cmd(8'h06);
        put(8'h53);
        put(8'h4f);
        put(8'h4c);
        cur(8'h03);
        check_val("line_shift0", 8'h00, {1'b0, line_shift[0]});
        peek(7'h01, 8'h4f);
        cmd(8'h17);
        cur(8'h04);
        peek(7'h03, 8'h20);
        cmd(8'h13);
        cur(8'h03);
        cmd(8'h1b);
        cur(8'h03);
        check_val("line_shift3", 8'h01, {1'b0, line_shift[3]});
        peek(7'h00, 8'h53);
        cmd(8'h07);
        check_flag("entry_shift", 1'b1, entry_shift);
        put(8'h59);
        cur(8'h04);
        check_val("line_shift0", 8'h02, {1'b0, line_shift[0]});
        peek(7'h03, 8'h59);
        cmd(8'h03);
        cur(8'h00);
        check_val("line_shift0", 8'h00, {1'b0, line_shift[0]});
        peek(7'h00, 8'h53);
        // A read cycle has no effect on memory or cursor
        u_lcdc_host_model.xfer(1'b1, 1'b1, 8'h41);
        peek(7'h00, 8'h53);
        cur(8'h00);
        cmd(8'h01);
        check_flag("busy", 1'b1, busy);
        cur(8'h00);
        wait_idle(n);
        // One edge of the pass was already spent inside the transfer
        check_val("clear_cycles", 8'h7f, n);
        peek(7'h00, 8'h20);
        cmd(8'h3c);
        check_flag("ext_cmd_page", 1'b1, ext_cmd_page);
        check_flag("iface_8bit", 1'b1, iface_8bit);
        cmd(8'h09);
        check_flag("four_line", 1'b1, four_line);
        check_flag("font_wide", 1'b0, font_wide);
        cmd(8'h38);
        check_flag("ext_cmd_page", 1'b0, ext_cmd_page);
        // Clear keeps the display-shift entry; drop it so line writes leave offsets
        cmd(8'h06);
        for (int i = 0; i < 3; i++) begin
            cmd(line_start[i]);
            cur(line_start[i] & 8'h7f);
        end
        put(8'h52);
        check_val("line_shift3", 8'h00, {1'b0, line_shift[3]});
        peek(7'h60, 8'h52);
        cmd(8'h3a);
        check_flag("double_height", 1'b1, double_height);
        check_flag("ext_cmd_page", 1'b0, ext_cmd_page);
        cmd(8'h3c);
        cmd(8'h18);
        check_flag("line4_shift_enable", 1'b1, line4_shift_enable);
        check_val("line3_line2", 8'h00, {6'h00, line3_line2_shift_enable});
        check_flag("line1_shift_enable", 1'b0, line1_shift_enable);
        cmd(8'h3a);
        check_flag("ext_cmd_page", 1'b0, ext_cmd_page);
        cmd(8'h18);
        check_val("line_shift3", 8'h01, {1'b0, line_shift[3]});
        check_val("line_shift0", 8'h00, {1'b0, line_shift[0]});
        check_val("line_shift2", 8'h00, {1'b0, line_shift[2]});
        final_report();
    end
endmodule
